// file: common/aal_consts.vh
`ifndef AAL_CONSTS_VH
`define AAL_CONSTS_VH

// Printed register indices; the byte address is four times the index.
`define AAL_IDX_STATUS 16'h1E83
`define AAL_IDX_WORKING_ACCUMULATOR 16'h1E89
`define AAL_ADDR_STATUS 18'h07A0C
`define AAL_ADDR_WORKING_ACCUMULATOR 18'h07A24

// Block-local registers.
`define AAL_ADDR_INSTR 18'h00400
`define AAL_ADDR_RESULT 18'h00404
`define AAL_ADDR_COUNT 18'h00408
// Data memory window: 128 words from byte address 0x000 to 0x1FC.
`define AAL_MEM_TOP_BITS 9

// Status field positions.
`define AAL_ST_CARRY 0
`define AAL_ST_NIBBLE 1
`define AAL_ST_ZERO 2
`define AAL_ST_WMASK 8'h07

// Reset values.
`define AAL_RST_STATUS 8'h00
`define AAL_RST_WORKING_ACCUMULATOR 8'h00

// Instruction word layout.
`define AAL_OP_HI 9
`define AAL_OP_LO 8
`define AAL_OP_ADDC 2'h1
`define AAL_OP_ANDI 2'h2
`define AAL_DEST_BIT 7
`define AAL_FADDR_HI 6
`define AAL_LIT_HI 7
`define AAL_INSTR_W 10

// Geometry.
`define AAL_DW 8
`define AAL_MEM_AW 7
`define AAL_MEM_DEPTH 128

`endif

// file: design/aal_data_mem.v
`timescale 1ns/1ns
`default_nettype none

// Single-array data memory with registered read data.
module aal_data_mem (
  // Clock
  input wire pclk,
  // Access
  input wire we,
  input wire [6:0] addr,
  input wire [7:0] wdata,
  output reg [7:0] rdata_q
);

  reg [7:0] mem [0:127];

  always @(posedge pclk) begin
    if (we) begin
      mem[addr] <= wdata;
    end
    rdata_q <= mem[addr];
  end

endmodule

`default_nettype wire

// file: design/aal_accum_alu.v
// The APB register port was decided locally.
`timescale 1ns/1ns
`default_nettype none
`include "aal_consts.vh"

// Notes on behaviour
// - Add-with-carry sums accumulator, carry flag and memory byte; sets carry, nibble carry, zero.
// - Add-with-carry destination bit 0 writes accumulator, 1 writes the memory byte.
// - Memory operand field is 7 bits, 0 to 127; destination field is one bit.
// - And-immediate ANDs the accumulator with an 8-bit literal, any value 0 to 255.
// - And-immediate always writes the accumulator and changes only the zero flag.
module aal_accum_alu (
  // Clock and reset
  input wire pclk,
  input wire presetn,
  // APB slave
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [17:0] paddr,
  input wire [31:0] pwdata,
  output reg [31:0] prdata,
  output reg pready,
  output reg pslverr,
  // Core-facing state
  output reg [7:0] accum_out,
  output reg [2:0] flags_out
);

  localparam S_IDLE = 2'd0;
  localparam S_MRD = 2'd1;
  localparam S_EXEC = 2'd2;

  reg [1:0] state_q, state_d;
  reg [7:0] working_accumulator_q, working_accumulator_d;
  reg [7:0] status_q, status_d;
  reg [9:0] instr_q, instr_d;
  reg [7:0] result_q, result_d;
  reg [15:0] count_q, count_d;
  reg [31:0] prdata_d;
  reg pready_d;
  reg pslverr_d;

  reg mem_we;
  reg [6:0] mem_addr;
  reg [7:0] mem_wdata;
  wire [7:0] mem_rdata;

  wire access = psel & penable & ~pready;
  wire in_mem = (paddr[17:`AAL_MEM_TOP_BITS] == 9'h000);
  wire [1:0] wr_op = pwdata[`AAL_OP_HI:`AAL_OP_LO];
  wire [6:0] wr_faddr = pwdata[`AAL_FADDR_HI:0];
  wire [7:0] wr_lit = pwdata[`AAL_LIT_HI:0];
  wire [6:0] ex_faddr = instr_q[`AAL_FADDR_HI:0];
  wire ex_dest = instr_q[`AAL_DEST_BIT];

  // Add datapath: a nine-bit sum and a five-bit nibble sum keep the carries out of bit 7 and bit 3.
  wire [8:0] sum9 = {1'b0, working_accumulator_q} + {1'b0, mem_rdata} + {8'h00, status_q[`AAL_ST_CARRY]};
  wire [4:0] nib5 = {1'b0, working_accumulator_q[3:0]} + {1'b0, mem_rdata[3:0]} + {4'h0, status_q[`AAL_ST_CARRY]};
  wire [7:0] and8 = working_accumulator_q & wr_lit;

  aal_data_mem u_mem (
    .pclk(pclk),
    .we(mem_we),
    .addr(mem_addr),
    .wdata(mem_wdata),
    .rdata_q(mem_rdata)
  );

  always @* begin
    state_d = state_q;
    working_accumulator_d = working_accumulator_q;
    status_d = status_q;
    instr_d = instr_q;
    result_d = result_q;
    count_d = count_q;
    prdata_d = 32'h00000000;
    pready_d = 1'b0;
    pslverr_d = 1'b0;
    mem_we = 1'b0;
    mem_addr = paddr[8:2];
    mem_wdata = pwdata[7:0];
    case (state_q)
      S_IDLE: begin
        if (access) begin
          if (in_mem) begin
            if (pwrite) begin
              mem_we = 1'b1;
              pready_d = 1'b1;
            end else begin
              state_d = S_MRD;
            end
          end else if (paddr == `AAL_ADDR_WORKING_ACCUMULATOR) begin
            if (pwrite) begin
              working_accumulator_d = pwdata[7:0];
            end
            prdata_d = {24'h000000, working_accumulator_q};
            pready_d = 1'b1;
          end else if (paddr == `AAL_ADDR_STATUS) begin
            if (pwrite) begin
              status_d = pwdata[7:0] & `AAL_ST_WMASK;
            end
            prdata_d = {24'h000000, status_q};
            pready_d = 1'b1;
          end else if (paddr == `AAL_ADDR_RESULT) begin
            prdata_d = {24'h000000, result_q};
            pready_d = 1'b1;
          end else if (paddr == `AAL_ADDR_COUNT) begin
            if (pwrite) begin
              count_d = 16'h0000;
            end
            prdata_d = {16'h0000, count_q};
            pready_d = 1'b1;
          end else if (paddr == `AAL_ADDR_INSTR) begin
            prdata_d = {22'h0, instr_q};
            if (!pwrite) begin
              pready_d = 1'b1;
            end else if (wr_op == `AAL_OP_ADDC) begin
              instr_d = pwdata[9:0];
              mem_addr = wr_faddr;
              state_d = S_EXEC;
            end else if (wr_op == `AAL_OP_ANDI) begin
              instr_d = pwdata[9:0];
              working_accumulator_d = and8;
              status_d[`AAL_ST_ZERO] = (and8 == 8'h00);
              result_d = and8;
              count_d = count_q + 16'h0001;
              pready_d = 1'b1;
            end else begin
              pslverr_d = 1'b1;
              pready_d = 1'b1;
            end
          end else begin
            pslverr_d = 1'b1;
            pready_d = 1'b1;
          end
        end
      end
      S_MRD: begin
        prdata_d = {24'h000000, mem_rdata};
        pready_d = 1'b1;
        state_d = S_IDLE;
      end
      S_EXEC: begin
        // Memory byte for the operand arrived this cycle.
        mem_addr = ex_faddr;
        mem_wdata = sum9[7:0];
        if (ex_dest) begin
          mem_we = 1'b1;
        end else begin
          working_accumulator_d = sum9[7:0];
        end
        status_d[`AAL_ST_CARRY] = sum9[8];
        status_d[`AAL_ST_NIBBLE] = nib5[4];
        status_d[`AAL_ST_ZERO] = (sum9[7:0] == 8'h00);
        result_d = sum9[7:0];
        count_d = count_q + 16'h0001;
        pready_d = 1'b1;
        state_d = S_IDLE;
      end
      default: begin
        state_d = S_IDLE;
      end
    endcase
  end

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_q <= S_IDLE;
      working_accumulator_q <= `AAL_RST_WORKING_ACCUMULATOR;
      status_q <= `AAL_RST_STATUS;
      instr_q <= 10'h000;
      result_q <= 8'h00;
      count_q <= 16'h0000;
      prdata <= 32'h00000000;
      pready <= 1'b0;
      pslverr <= 1'b0;
      accum_out <= `AAL_RST_WORKING_ACCUMULATOR;
      flags_out <= 3'h0;
    end else begin
      state_q <= state_d;
      working_accumulator_q <= working_accumulator_d;
      status_q <= status_d;
      instr_q <= instr_d;
      result_q <= result_d;
      count_q <= count_d;
      prdata <= prdata_d;
      pready <= pready_d;
      pslverr <= pslverr_d;
      accum_out <= working_accumulator_d;
      flags_out <= status_d[2:0];
    end
  end

endmodule

`default_nettype wire

// file: dv/aal_accum_alu_props.sv
`timescale 1ns/1ns
`default_nettype none
`include "aal_consts.vh"
module aal_accum_alu_props (
  // Clock and reset
  input wire pclk,
  input wire presetn,
  // APB
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [17:0] paddr,
  input wire [31:0] pwdata,
  input wire [31:0] prdata,
  input wire pready,
  input wire pslverr,
  // Core state
  input wire [7:0] accum_out,
  input wire [2:0] flags_out
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  wire ex = psel && penable && pready && pwrite && paddr == `AAL_ADDR_INSTR;
  wire andi = ex && pwdata[9:8] == 2'h2;
  wire addc = ex && pwdata[9:8] == 2'h1;
  a_andi_result: assert property (andi |-> accum_out == ($past(accum_out) & pwdata[7:0]))
    else $error("and result wrong");
  a_andi_flags: assert property (andi |-> $stable(flags_out[1:0]) && flags_out[2] == (accum_out == 8'h00))
    else $error("and flags wrong");
  a_addc_zero: assert property (addc && !pwdata[7] |-> flags_out[2] == (accum_out == 8'h00))
    else $error("add zero flag wrong");
  a_addc_keep: assert property (addc && pwdata[7] |-> $stable(accum_out))
    else $error("add to memory changed accumulator");
  a_addc_taken: assert property (addc |-> !pslverr)
    else $error("add refused");
  a_bad_op: assert property (ex && pwdata[9:8] == 2'h0 |-> pslverr && $stable(accum_out))
    else $error("bad opcode accepted");
  a_ready_pulse: assert property (pready |=> !pready)
    else $error("ready longer than one cycle");
  cover property (andi);
  cover property (addc && pwdata[7]);
  cover property (addc && !pwdata[7] && flags_out[0]);
endmodule
`default_nettype wire

// file: dv/accumulator_add_and_logic_tb.sv
`timescale 1ns/1ns
`default_nettype none
`include "aal_consts.vh"
`define CHK(a, e) begin checks++; if ((a) !== (e)) begin mismatches++; $display("[FAIL] %0t got %h exp %h", $time, a, e); end end
module accumulator_add_and_logic_tb;
  logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
  logic [17:0] paddr = 0;
  logic [31:0] pwdata = 0;
  wire [31:0] prdata;
  wire pready, pslverr;
  wire [7:0] accum_out;
  wire [2:0] flags_out;
  int mismatches = 0, checks = 0;
  logic [32:0] q[$];
  logic [32:0] e;
  aal_accum_alu dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .accum_out(accum_out), .flags_out(flags_out));
  initial forever #5 pclk = ~pclk;
  // Writes are judged on the error bit alone; reads on error bit and data.
  always @(negedge pclk) if (psel && penable && pready === 1'b1) begin
    e = q.pop_front();
    if (pwrite) `CHK(pslverr, e[32])
    else `CHK({pslverr, prdata}, e)
  end
  task automatic apb(input logic w, input logic [17:0] a, input logic [31:0] d, input logic [32:0] x);
    q.push_back(x);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk) penable <= 1'b1;
    do @(negedge pclk); while (pready !== 1'b1);
    @(posedge pclk) begin
      psel <= 1'b0;
      penable <= 1'b0;
    end
    @(posedge pclk);
  endtask
  task automatic results;
    $display("checks %0d mismatches %0d", checks, mismatches);
    if (mismatches == 0 && checks > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  initial begin
    logic [31:0] r, r2;
    logic [8:0] sum;
    logic [7:0] s;
    logic [2:0] st;
    void'($urandom(10));
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    apb(0, `AAL_ADDR_WORKING_ACCUMULATOR, 0, 33'h0);
    apb(0, `AAL_ADDR_STATUS, 0, 33'h0);
    apb(0, 18'h00200, 0, {1'b1, 32'h0});
    apb(1, `AAL_ADDR_INSTR, 32'h300, {1'b1, 32'h0});
    $display("test reset_and_refusal done");
    for (int i = 0; i < 24; i++) begin
      r = $urandom;
      r2 = $urandom;
      if (i == 0) r2[6:0] = 7'h7F;
      if (i == 1) r[24:0] = 25'h10007F8;
      if (i < 2) r[23:16] = {8{i[0]}};
      apb(1, `AAL_ADDR_WORKING_ACCUMULATOR, {r2[31:8], r[7:0]}, 33'h0);
      apb(1, `AAL_ADDR_STATUS, {23'h0, 5'h1F, r[28:26], r[24]}, 33'h0);
      apb(1, {9'h0, r2[6:0], 2'h0}, {24'h0, r[15:8]}, 33'h0);
      sum = r[7:0] + r[15:8] + r[24];
      s = r[25] ? r[7:0] : sum[7:0];
      st = {sum[7:0] == 8'h00, ({1'b0, r[3:0]} + r[11:8] + r[24]) > 5'h0F, sum[8]};
      apb(1, `AAL_ADDR_INSTR, {22'h0, 2'h1, r[25], r2[6:0]}, 33'h0);
      apb(0, `AAL_ADDR_WORKING_ACCUMULATOR, 0, {25'h0, s});
      apb(0, {9'h0, r2[6:0], 2'h0}, 0, {25'h0, r[25] ? sum[7:0] : r[15:8]});
      apb(0, `AAL_ADDR_STATUS, 0, {30'h0, st});
      `CHK(accum_out, s)
      `CHK(flags_out, st)
      apb(1, `AAL_ADDR_INSTR, {22'h0, 2'h2, r[23:16]}, 33'h0);
      s = s & r[23:16];
      st[2] = s == 8'h00;
      apb(0, `AAL_ADDR_WORKING_ACCUMULATOR, 0, {25'h0, s});
      apb(0, `AAL_ADDR_STATUS, 0, {30'h0, st});
      `CHK(accum_out, s)
      `CHK(flags_out, st)
    end
    $display("test datapath_random done");
    results();
  end
  initial begin
    #100000;
    mismatches++;
    results();
  end
endmodule
bind aal_accum_alu aal_accum_alu_props u_props (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
  .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .accum_out(accum_out), .flags_out(flags_out));
`default_nettype wire
